// ---- core/tfa_frame_align.sv ----
// Purpose: Frame sync, bit counter, framing output, multiframe timer, edges
// Assumes: Link clocks far slower than pclk (at least 4 pclk per phase)
// Notes: APB slave with one wait state; prescaler and memories live elsewhere
// Functional notes
// - Multiframe mode: reset marker one bit wide, other pulses at least two bits.
// - On each timer expiry one frame uses the short shape, others the long.
// - Start command loads inverted timer value; first step after slot 3, then 250 us.
// - Timer reaching zero raises the expiry output at once; next pulse short.
// - A stopped timer gives only the long pulse shape.
// - Frame length is frame_bit_count plus one bits; 8 kHz frame rate.
// - Frame syncs on a low-to-high of pcm or port framing input, by source select.
// - Framing input sampled on falling edge when edge select 0, rising when 1.
// - Falling-edge sampling delays internal frame start by one data clock.
// - Zero offset marks bit 7 of the marked slot; slot adjust holds it plus 2.
// - Shift code 000/001 mark previous slot bits 1/0; 010..111 mark bits 7..2.
// - Bit shift acts alike on upstream and downstream positions.
// - Upstream shift 0 aligns; 1..15 moves upstream left by that many bits.
// - With pcm source, shifts move data and framing output together.
// - Tx edge 0 launches on rising ref edge, 1 on next falling edge.
// - Rx edge 0 samples on falling ref edge, 1 on next rising edge.
// - Long shape rises at slot 0 bit 7 and stays high 32 bits.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module tfa_frame_align
    import tfa_pkg::*;
#(
    parameter int TICK_CYC = TFA_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pcm_frame_sync,
    input wire logic pcm_data_clock,
    input wire logic port_data_clock,
    input wire logic port_frame_pin_i,
    output logic port_frame_pin_o,
    output logic port_frame_pin_oe_n,
    input wire logic upward_data_pin,
    output logic downward_data_pin,
    input wire logic tx_bit,
    output logic [9:0] down_bit_index,
    output logic rx_bit,
    output logic rx_valid,
    output logic [9:0] up_bit_index,
    output logic timer_expired
);
    logic [1:0] mode_a_r;
    logic [2:0] frm_mode_r;
    logic tx_edge_r, rx_edge_r;
    logic [9:0] nbits_r;
    logic [6:0] slot_adj_r, shift_r, timer_period_value_r, timer_r;
    logic [4:0] pin_s;
    logic clk_d_r, fs_smp_r, pend1_r, pend2_r, locked_r, tx_pend_r, rx_pend_r;
    logic [9:0] cnt_r, cnt_nxt, start_val;
    logic [10:0] up_sum;
    logic [11:0] sv_raw;
    logic run_r, first_r, short_pend_r, frame_short_r;
    logic [12:0] tick_r;
    logic ref_clk, fs_sel, ref_rise, ref_fall, smp_edge, fs_rise_det, frame_start;
    logic wr_en, go_wr, stop_wr, timer_step;

    // ========================================
    // Pin synchronisers: clocks, framing inputs and upstream data
    tfa_sync2 #(.W(5)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({upward_data_pin, port_frame_pin_i, pcm_frame_sync,
                   port_data_clock, pcm_data_clock}),
        .sync_out(pin_s)
    );

    // Source select picks clock and framing input together
    assign ref_clk = mode_a_r[TFA_SRC_BIT] ? pin_s[1] : pin_s[0];
    assign fs_sel = mode_a_r[TFA_SRC_BIT] ? pin_s[3] : pin_s[2];
    assign ref_rise = ref_clk & ~clk_d_r;
    assign ref_fall = ~ref_clk & clk_d_r;
    assign smp_edge = mode_a_r[TFA_EDGE_BIT] ? ref_rise : ref_fall;
    assign fs_rise_det = smp_edge & fs_sel & ~fs_smp_r;
    // Rising sampling starts at once; falling sampling waits one data clock
    assign frame_start = ref_rise &
        ((fs_rise_det & mode_a_r[TFA_EDGE_BIT]) | pend2_r);

    // ========================================
    // APB slave: one wait state, error on unmapped addresses
    assign wr_en = psel & penable & pready & pwrite;
    assign go_wr = wr_en & (paddr == TFA_COMMAND_OFS) & pwdata[TFA_GO_BIT];
    assign stop_wr = wr_en & (paddr == TFA_COMMAND_OFS) & pwdata[TFA_STOP_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel & penable & ~pready) begin
                case (paddr)
                    TFA_PORT_MODE_A_OFS: prdata <= {30'h0, mode_a_r};
                    TFA_PORT_MODE_B_OFS: prdata <= {27'h0, rx_edge_r, tx_edge_r, frm_mode_r};
                    TFA_FRAME_BITS_OFS: prdata <= {22'h0, nbits_r};
                    TFA_SLOT_ADJUST_OFS: prdata <= {25'h0, slot_adj_r};
                    TFA_BIT_SHIFT_OFS: prdata <= {25'h0, shift_r};
                    TFA_MF_TIMER_OFS: prdata <= {25'h0, timer_period_value_r};
                    TFA_COMMAND_OFS: prdata <= 32'h0000_0000;
                    TFA_STATUS_OFS: prdata <= {6'h0, cnt_r, 5'h0, timer_r,
                                               1'b0, frame_short_r, locked_r, run_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Configuration registers take writes only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_a_r <= TFA_MODE_A_RST;
            frm_mode_r <= TFA_FRM_RST;
            tx_edge_r <= 1'b0;
            rx_edge_r <= 1'b0;
            nbits_r <= TFA_FRAME_BITS_RST;
            slot_adj_r <= TFA_SLOT_ADJ_RST;
            shift_r <= TFA_SHIFT_RST;
            timer_period_value_r <= TFA_TIMER_PERIOD_VALUE_RST;
        end else if (ce && wr_en) begin
            case (paddr)
                TFA_PORT_MODE_A_OFS: mode_a_r <= pwdata[1:0];
                TFA_PORT_MODE_B_OFS: begin
                    frm_mode_r <= pwdata[2:0];
                    tx_edge_r <= pwdata[TFA_TXE_BIT];
                    rx_edge_r <= pwdata[TFA_RXE_BIT];
                end
                TFA_FRAME_BITS_OFS: nbits_r <= pwdata[9:0];
                TFA_SLOT_ADJUST_OFS: slot_adj_r <= pwdata[6:0];
                TFA_BIT_SHIFT_OFS: shift_r <= pwdata[6:0];
                TFA_MF_TIMER_OFS: timer_period_value_r <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // Frame position: marked bit = (adjust-2)*8 + (code-2), negative values wrapped into the frame
    always_comb begin
        sv_raw = {2'b00, slot_adj_r, 3'b000} + {9'h000, shift_r[6:4]} - TFA_ALIGN_BIAS;
        if (sv_raw[11]) begin
            start_val = 10'(sv_raw + {2'b00, nbits_r} + 12'h001);
        end else begin
            start_val = sv_raw[9:0];
        end
    end

    // Counter wraps after nbits; a frame sync reloads the marked position
    always_comb begin
        if (frame_start) begin
            cnt_nxt = start_val;
        end else if (cnt_r >= nbits_r) begin
            cnt_nxt = 10'h000;
        end else begin
            cnt_nxt = cnt_r + 10'h001;
        end
    end

    // Upstream runs ahead of downstream by the upward shift
    always_comb begin
        up_sum = {1'b0, cnt_r} + {7'h00, shift_r[3:0]};
        if (up_sum > {1'b0, nbits_r}) begin
            up_sum = up_sum - {1'b0, nbits_r} - 11'h001;
        end
    end

    // Edge tracking and framing sample history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d_r <= 1'b0;
            fs_smp_r <= 1'b1;
            pend1_r <= 1'b0;
            pend2_r <= 1'b0;
        end else if (ce) begin
            clk_d_r <= ref_clk;
            if (smp_edge) begin
                fs_smp_r <= fs_sel;
            end
            if (ref_rise) begin
                pend2_r <= pend1_r;
                pend1_r <= 1'b0;
            end
            if (fs_rise_det && !mode_a_r[TFA_EDGE_BIT]) begin
                pend1_r <= 1'b1;
            end
        end
    end

    // Bit counter advances on each rising reference edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 10'h000;
            locked_r <= 1'b0;
        end else if (ce && ref_rise) begin
            cnt_r <= cnt_nxt;
            if (frame_start) begin
                locked_r <= 1'b1;
            end
        end
    end

    // ========================================
    // Multiframe timer: counts up from the inverted period to zero
    assign timer_step = first_r ? (ref_rise && cnt_nxt == TFA_SLOT3_END)
                                : (tick_r == 13'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            first_r <= 1'b0;
            timer_r <= 7'h00;
            tick_r <= 13'h0000;
            timer_expired <= 1'b0;
        end else if (ce) begin
            timer_expired <= 1'b0;
            if (go_wr) begin
                run_r <= 1'b1;
                first_r <= 1'b1;
                timer_r <= ~timer_period_value_r;
                tick_r <= 13'h0000;
            end else if (stop_wr) begin
                run_r <= 1'b0;
            end else if (run_r) begin
                tick_r <= timer_step ? 13'h0000 : tick_r + 13'h0001;
                if (timer_step) begin
                    first_r <= 1'b0;
                    if (timer_r == 7'h7F) begin
                        timer_r <= ~timer_period_value_r; // Cyclic: reload for the next period
                        timer_expired <= 1'b1;
                    end else begin
                        timer_r <= timer_r + 7'h01;
                    end
                end
            end
        end
    end

    // Expiry arms the short shape for the next framing pulse only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_pend_r <= 1'b0;
            frame_short_r <= 1'b0;
        end else if (ce) begin
            if (ref_rise && cnt_nxt == 10'h000) begin
                frame_short_r <= short_pend_r & run_r;
            end
            if (!run_r) begin
                short_pend_r <= 1'b0;
            end else if (timer_expired) begin
                short_pend_r <= 1'b1;
            end else if (ref_rise && cnt_nxt == 10'h000) begin
                short_pend_r <= 1'b0;
            end
        end
    end

    // ========================================
    // Framing output, driven only when pcm clocks are the source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_frame_pin_o <= 1'b0;
            port_frame_pin_oe_n <= 1'b1;
        end else if (ce) begin
            port_frame_pin_oe_n <= mode_a_r[TFA_SRC_BIT];
            if (ref_rise) begin
                if (frm_mode_r == TFA_FRM_SHORT ||
                    (frm_mode_r == TFA_FRM_MULTI && (cnt_nxt == 10'h000 ?
                     short_pend_r & run_r : frame_short_r))) begin
                    port_frame_pin_o <= (cnt_nxt == 10'h000);
                end else begin
                    port_frame_pin_o <= (cnt_nxt < TFA_LONG_BITS);
                end
            end
        end
    end

    // ========================================
    // Data timing: launch and sample on the selected reference edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            downward_data_pin <= 1'b1;
            down_bit_index <= 10'h000;
            tx_pend_r <= 1'b0;
        end else if (ce) begin
            if (ref_rise) begin
                down_bit_index <= cnt_nxt;
                tx_pend_r <= tx_edge_r;
                if (!tx_edge_r) begin
                    downward_data_pin <= tx_bit;
                end
            end else if (ref_fall && tx_pend_r) begin
                downward_data_pin <= tx_bit;
                tx_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_bit <= 1'b0;
            rx_valid <= 1'b0;
            up_bit_index <= 10'h000;
            rx_pend_r <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            if (ref_fall) begin
                rx_pend_r <= rx_edge_r;
                if (!rx_edge_r) begin
                    rx_bit <= pin_s[4];
                    rx_valid <= 1'b1;
                    up_bit_index <= up_sum[9:0];
                end
            end else if (ref_rise && rx_pend_r) begin
                rx_bit <= pin_s[4];
                rx_valid <= 1'b1;
                up_bit_index <= up_sum[9:0];
                rx_pend_r <= 1'b0;
            end
        end
    end

    // ========================================
    // Checks: pulse widths counted in reference rising edges
    logic [9:0] hi_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_r <= 10'h000;
        end else if (ce && ref_rise) begin
            hi_cnt_r <= port_frame_pin_o ? hi_cnt_r + 10'h001 : 10'h000;
        end
    end

    AST_LONG_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ref_rise && port_frame_pin_o && !frame_start && !frame_short_r &&
        frm_mode_r == TFA_FRM_LONG && cnt_r == 10'h01F |=> !port_frame_pin_o)
        else $error("long framing pulse did not end after 32 bits");
    AST_SHORT_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ref_rise && port_frame_pin_o && hi_cnt_r == 10'h001 && !frame_start &&
        frm_mode_r == TFA_FRM_MULTI |-> !frame_short_r)
        else $error("short framing pulse wider than one bit");
    AST_TIMER_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        ce && go_wr |=> timer_r == ~$past(timer_period_value_r) && run_r)
        else $error("timer not loaded with inverted value");
    AST_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
        ce && run_r && !go_wr && !stop_wr && timer_step && timer_r == 7'h7F
        |=> timer_expired ##1 short_pend_r)
        else $error("timer expiry not signalled");
    AST_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !run_r |=> !short_pend_r)
        else $error("short shape armed while timer stopped");
    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ref_rise && !frame_start && cnt_r >= nbits_r |=> cnt_r == 10'h000)
        else $error("bit counter did not wrap");
    AST_SYNC_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        ce && frame_start |=> cnt_r == $past(start_val))
        else $error("frame sync did not load marked position");
    AST_FALL_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
        ce && fs_rise_det && !mode_a_r[TFA_EDGE_BIT] |-> !frame_start)
        else $error("falling-edge sync started frame without delay");
    AST_UP_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
        ce && ref_fall && !rx_edge_r && cnt_r + 10'(shift_r[3:0]) <= nbits_r
        |=> up_bit_index == $past(cnt_r) + 10'($past(shift_r[3:0])))
        else $error("upstream index not shifted");
    AST_OE: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !mode_a_r[TFA_SRC_BIT] |=> !port_frame_pin_oe_n)
        else $error("framing output not driven with pcm source");

    COV_SYNC: cover property (@(posedge pclk) disable iff (!presetn) frame_start);
    COV_EXPIRE: cover property (@(posedge pclk) disable iff (!presetn) timer_expired);
    COV_SHORT: cover property (@(posedge pclk) disable iff (!presetn)
        frame_short_r && port_frame_pin_o);
endmodule

// ---- core/tfa_pkg.sv ----
// Purpose: Shared constants for the frame sync and bit alignment block
// Assumes: APB data 32 bits, 20 MHz pclk
// Notes: Register offsets are byte addresses of aligned words
package tfa_pkg;
    // ========================================
    // Register map
    localparam logic [7:0] TFA_PORT_MODE_A_OFS = 8'h00;
    localparam logic [7:0] TFA_PORT_MODE_B_OFS = 8'h04;
    localparam logic [7:0] TFA_FRAME_BITS_OFS = 8'h08;
    localparam logic [7:0] TFA_SLOT_ADJUST_OFS = 8'h0C;
    localparam logic [7:0] TFA_BIT_SHIFT_OFS = 8'h10;
    localparam logic [7:0] TFA_MF_TIMER_OFS = 8'h14;
    localparam logic [7:0] TFA_COMMAND_OFS = 8'h18;
    localparam logic [7:0] TFA_STATUS_OFS = 8'h1C;
    // ========================================
    // Field positions
    localparam int TFA_SRC_BIT = 0;
    localparam int TFA_EDGE_BIT = 1;
    localparam int TFA_TXE_BIT = 3;
    localparam int TFA_RXE_BIT = 4;
    localparam int TFA_GO_BIT = 0;
    localparam int TFA_STOP_BIT = 1;
    localparam int TFA_STAT_RUN_BIT = 0;
    localparam int TFA_STAT_LOCK_BIT = 1;
    localparam int TFA_STAT_SHORT_BIT = 2;
    localparam int TFA_STAT_CNT_LSB = 16;
    // ========================================
    // Reset values
    localparam logic [1:0] TFA_MODE_A_RST = 2'h0;
    localparam logic [2:0] TFA_FRM_RST = 3'h6;
    localparam logic [9:0] TFA_FRAME_BITS_RST = 10'h0FF;
    localparam logic [6:0] TFA_SLOT_ADJ_RST = 7'h02;
    localparam logic [6:0] TFA_SHIFT_RST = 7'h20;
    localparam logic [6:0] TFA_TIMER_PERIOD_VALUE_RST = 7'h00;
    // ========================================
    // Framing control modes and alignment constants
    localparam logic [2:0] TFA_FRM_SHORT = 3'h3;
    localparam logic [2:0] TFA_FRM_LONG = 3'h6;
    localparam logic [2:0] TFA_FRM_MULTI = 3'h7;
    localparam logic [9:0] TFA_LONG_BITS = 10'h020;
    localparam logic [9:0] TFA_SLOT3_END = 10'h020;
    localparam logic [11:0] TFA_ALIGN_BIAS = 12'h012;
    // ========================================
    // Timing
    localparam int TFA_CLK_PERIOD_NS = 50;
    localparam int TFA_TICK_US = 250;
    localparam int TFA_TICK_CYC = (TFA_TICK_US * 1000) / TFA_CLK_PERIOD_NS;
endpackage

// ---- core/tfa_sync2.sv ----
// Purpose: Two-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are quasi-static relative to pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module tfa_sync2 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // ========================================
    // Two flops; frozen with the clock enable like the rest of the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for frame sync and bit alignment
// Assumes: 64-bit frames, short timer tick for run time
// Notes: Drivers queue expectations, monitors pop and compare
`timescale 1ns/1ps
module testbench;
    import tfa_pkg::*;
    localparam int FBITS = 64;
    logic pclk, presetn, psel, penable, pwrite, tx_bit, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pcm_fs, pcm_clk, up_pin, fr_o, fr_oe_n, dn_pin, rx_bit, rx_valid, t_exp;
    logic tx_d, rx_d;
    logic [9:0] dn_idx, up_idx, di_d;
    logic [32:0] rq[$];
    logic [19:0] iq[$];
    int wq[$];
    int n_fail = 0, n_tests = 0, wlen = 0, sa, us, dn, n, rx_n = 0, dly = 12;
    logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
    logic [31:0] rv[8] = '{32'h0000_0000, 32'h0000_0006, 32'h0000_00FF, 32'h0000_0002,
        32'h0000_0020, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    wire fr_i = fr_oe_n ? pcm_fs : fr_o;
    // ========================================
    // Design and far end
    tfa_frame_align #(.TICK_CYC(20)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pcm_frame_sync(pcm_fs),
        .pcm_data_clock(pcm_clk), .port_data_clock(pcm_clk), .port_frame_pin_i(fr_i),
        .port_frame_pin_o(fr_o), .port_frame_pin_oe_n(fr_oe_n), .upward_data_pin(up_pin),
        .downward_data_pin(dn_pin), .tx_bit(tx_bit), .down_bit_index(dn_idx),
        .rx_bit(rx_bit), .rx_valid(rx_valid), .up_bit_index(up_idx), .timer_expired(t_exp));
    tfa_far_end #(.FRAME_BITS(FBITS)) i_far (.pcm_data_clock(pcm_clk), .pcm_frame_sync(pcm_fs),
        .upward_data_pin(up_pin));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ========================================
    // Shared tasks
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        rq.push_back({err, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Waits out the running pulse, then expects the next width
    task automatic width_is(input int w);
        @(negedge fr_o);
        // Second edge: the monitor has closed the running pulse by then
        repeat (2) @(posedge pclk);
        wq.push_back(w);
        while (wq.size() != 0) @(posedge pclk);
    endtask
    // ========================================
    // Monitors
    always @(posedge pclk) begin
        tx_bit <= 1'($urandom_range(0, 1));
        // Index and downstream pin move together; pin carries the bit seen then
        if (presetn && dn_idx !== di_d) chk(33'(tx_d), 33'(dn_pin));
        if (rx_valid === 1'b1) begin
            if (rx_n != 0) chk(33'(!rx_d), 33'(rx_bit));
            rx_n++;
            rx_d = rx_bit;
        end
        di_d = dn_idx;
        tx_d = tx_bit;
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() != 0)
            chk(rq.pop_front(), {pslverr, prdata});
        if (fr_o === 1'b1) wlen++;
        else if (wlen != 0) begin
            if (wq.size() != 0) chk(33'(wq.pop_front()), 33'(wlen));
            wlen = 0;
        end
    end
    // Counter must hold the marked position one bit after sync is seen
    always @(posedge pcm_fs) begin
        repeat (dly) @(posedge pclk);
        if (iq.size() != 0) chk(33'(iq.pop_front()), 33'({dn_idx, up_idx}));
    end
    initial begin
        repeat (90000) @(posedge pclk);
        n_fail++;
        summarize();
    end
    // ========================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        tx_bit = 1'b0;
        void'($urandom(64930));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i], i == 7);
        apb(1'b1, TFA_FRAME_BITS_OFS, 32'h0000_003F);
        apb(1'b1, TFA_PORT_MODE_A_OFS, 32'h0000_0002);
        for (int i = 0; i < 8; i++) begin
            sa = 2 + $urandom_range(0, 3);
            us = $urandom_range(0, 15);
            apb(1'b1, TFA_SLOT_ADJUST_OFS, 32'(sa));
            apb(1'b1, TFA_BIT_SHIFT_OFS, 32'((i << 4) | us));
            repeat (2) @(posedge pcm_fs);
            dn = (((sa - 2) * 8 + i - 2) % FBITS + FBITS) % FBITS;
            iq.push_back({10'(dn), 10'((dn + us) % FBITS)});
            while (iq.size() != 0) @(posedge pclk);
        end
        // Falling-edge sampling: same marked position, loaded one data clock later
        apb(1'b1, TFA_PORT_MODE_A_OFS, 32'h0000_0000);
        dly = 21;
        repeat (2) @(posedge pcm_fs);
        iq.push_back({10'(dn), 10'((dn + us) % FBITS)});
        while (iq.size() != 0) @(posedge pclk);
        width_is(256);
        apb(1'b1, TFA_PORT_MODE_B_OFS, 32'h0000_0007);
        width_is(256);
        apb(1'b1, TFA_MF_TIMER_OFS, 32'h0000_0001);
        rd(TFA_MF_TIMER_OFS, 32'h0000_0001, 1'b0);
        apb(1'b1, TFA_COMMAND_OFS, 32'h0000_0001);
        n = 0;
        while (t_exp !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        chk(33'h1, 33'(n < 2000));
        width_is(8);
        apb(1'b1, TFA_COMMAND_OFS, 32'h0000_0002);
        width_is(256);
        summarize();
    end
endmodule

// ---- verification/tfa_far_end.sv ----
// Purpose: Far-end model: bus clock, frame sync and upstream bits
// Assumes: 400 ns bit period, clock runs free as on a TDM bus
// Notes: Sync pulse is two bits high, then low for the rest of the frame
`timescale 1ns/1ps
module tfa_far_end #(
    parameter int FRAME_BITS = 64
) (
    output logic pcm_data_clock,
    output logic pcm_frame_sync,
    output logic upward_data_pin
);
    int bit_n;
    // ========================================
    // Free-running bus clock
    initial begin
        pcm_data_clock = 1'b0;
        forever #200 pcm_data_clock = ~pcm_data_clock;
    end
    // Launch on the falling edge so the rising sample sees settled levels
    initial begin
        bit_n = 0;
        pcm_frame_sync = 1'b0;
        upward_data_pin = 1'b1;
        forever begin
            @(negedge pcm_data_clock);
            pcm_frame_sync <= (bit_n < 2);
            upward_data_pin <= ~upward_data_pin;
            bit_n = (bit_n + 1) % FRAME_BITS;
        end
    end
endmodule
